// file: include/pae_pkg.sv
// shared constants and types of the proximity / ambient event logic
// assumes a 200 MHz system clock and an apb master with 32-bit data
package pae_pkg;

   // =====================================================================
   // timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned AMB_BASE_MS = 50;
   localparam int unsigned AMB_BASE_CYCLES = AMB_BASE_MS * 1000 * CLK_MHZ;

   // =====================================================================
   // register byte offsets
   localparam logic [7:0] OFS_AMB_CONF = 8'h00;
   localparam logic [7:0] OFS_PROX_CONF = 8'h04;
   localparam logic [7:0] OFS_AMB_HIGH = 8'h08;
   localparam logic [7:0] OFS_AMB_LOW = 8'h0c;
   localparam logic [7:0] OFS_PROX_HIGH = 8'h10;
   localparam logic [7:0] OFS_PROX_LOW = 8'h14;
   localparam logic [7:0] OFS_CANCEL = 8'h18;
   localparam logic [7:0] OFS_PROX_RES0 = 8'h1c;
   localparam logic [7:0] OFS_PROX_RES1 = 8'h20;
   localparam logic [7:0] OFS_PROX_RES2 = 8'h24;
   localparam logic [7:0] OFS_AMB_RES = 8'h28;
   localparam logic [7:0] OFS_FLAGS = 8'h2c;
   localparam logic [7:0] OFS_ID = 8'h30;

   // =====================================================================
   // ambient config fields
   localparam int AMB_ON_BIT = 0;
   localparam int AMB_IRQ_EN_BIT = 1;
   localparam int AMB_PERS_LSB = 2;
   localparam int AMB_IT_LSB = 5;

   // =====================================================================
   // proximity config fields
   localparam int PROX_ON_BIT = 0;
   localparam int PROX_IRQ_SEL_LSB = 1;
   localparam int PROX_METHOD_BIT = 3;
   localparam int PROX_PERS_LSB = 4;
   localparam int PROX_PIN_SEL_BIT = 6;
   localparam int PROX_FORCED_BIT = 7;
   localparam int PROX_TRIG_BIT = 8;
   localparam int PROX_GESTURE_BIT = 9;
   localparam int PROX_EMIT_LSB = 10;

   // =====================================================================
   // flag byte fields
   localparam int FLG_GESTURE = 7;
   localparam int FLG_PROTECT = 6;
   localparam int FLG_AMB_LOW = 5;
   localparam int FLG_AMB_HIGH = 4;
   localparam int FLG_NEAR = 1;
   localparam int FLG_FAR = 0;

   // =====================================================================
   // reset values
   localparam logic [7:0] RST_AMB_CONF = 8'h00;
   localparam logic [11:0] RST_PROX_CONF = 12'h000;
   localparam logic [15:0] RST_HIGH_LIMIT = 16'hffff;
   localparam logic [15:0] RST_LOW_LIMIT = 16'h0000;
   // identity value is arbitrary
   localparam logic [15:0] DEVICE_ID = 16'h5a01;

   typedef enum logic {PAE_P_IDLE, PAE_P_WAIT} pae_pstate_t;

   typedef struct packed {
      logic [7:0] amb_conf;
      logic [11:0] prox_conf;
      logic [15:0] amb_high;
      logic [15:0] amb_low;
      logic [15:0] prox_high;
      logic [15:0] prox_low;
      logic [15:0] cancel;
      logic [2:0][15:0] prox_res;
      logic [15:0] amb_res;
      logic [7:0] flags;
      logic [31:0] amb_timer;
      logic [3:0] amb_cnt;
      logic [2:0] prox_cnt;
      logic near;
      pae_pstate_t pstate;
      logic [1:0] emitter;
      logic gesture_run;
      logic prox_req;
      logic [2:0] emit_sel;
      logic pin_o;
      logic pin_oe_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [2:0] lclk_s;
      logic [1:0] pvalid_s;
      logic [1:0][15:0] pdata_s;
      logic [1:0][15:0] adata_s;
      logic [2:0] prot_s;
   } pae_state_t;

endpackage

// file: logic/pae_top.sv
// event, threshold and readout logic of a proximity / ambient sensor
// assumes an apb master on MCLK and an analog front end on its own link clock
`timescale 1ns/1ps
module pae_top
   import pae_pkg::*;
#(
   parameter int unsigned AMB_BASE = AMB_BASE_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LINK_CLK,
   input wire logic PRX_VALID,
   input wire logic [15:0] PRX_DATA,
   input wire logic [15:0] AMB_DATA,
   input wire logic PROTECT_IN,
   output logic PRX_REQ,
   output logic [2:0] EMIT_SEL,
   output logic IRQ_PIN_O,
   output logic IRQ_PIN_OE_N
);

   pae_state_t s_reg;
   pae_state_t s_next;

   // =====================================================================
   // helpers
   function automatic logic [31:0] amb_period(input logic [2:0] sel);
      logic [2:0] sh;
      sh = 3'd4;
      unique case (sel)
         3'b000: sh = 3'd0;
         3'b001: sh = 3'd1;
         3'b010: sh = 3'd2;
         3'b011: sh = 3'd2;
         3'b100: sh = 3'd3;
         default: sh = 3'd4;
      endcase
      return AMB_BASE << sh;
   endfunction

   logic apb_done;
   logic apb_wr;
   logic apb_rd;
   logic [31:0] rd_word;
   logic rd_err;
   logic lclk_rise;
   logic [15:0] prox_raw;
   logic [15:0] prox_val;
   logic [7:0] fset;
   logic [7:0] irq_mask;
   logic irq_on;
   logic amb_tick;
   logic [3:0] amb_need;
   logic [3:0] amb_inc;
   logic amb_out;
   logic prox_out;
   logic [2:0] prox_inc;
   logic [1:0] emit_idx;
   logic start_ok;

   // =====================================================================
   // register readback
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      unique case (PADDR)
         OFS_AMB_CONF: rd_word = {24'h00_0000, s_reg.amb_conf};
         OFS_PROX_CONF: rd_word = {20'h0_0000, s_reg.prox_conf};
         OFS_AMB_HIGH: rd_word = {16'h0000, s_reg.amb_high};
         OFS_AMB_LOW: rd_word = {16'h0000, s_reg.amb_low};
         OFS_PROX_HIGH: rd_word = {16'h0000, s_reg.prox_high};
         OFS_PROX_LOW: rd_word = {16'h0000, s_reg.prox_low};
         OFS_CANCEL: rd_word = {16'h0000, s_reg.cancel};
         OFS_PROX_RES0: rd_word = {16'h0000, s_reg.prox_res[0]};
         OFS_PROX_RES1: rd_word = {16'h0000, s_reg.prox_res[1]};
         OFS_PROX_RES2: rd_word = {16'h0000, s_reg.prox_res[2]};
         // low byte in 7:0, high byte in 15:8, both in one read
         OFS_AMB_RES: rd_word = {16'h0000, s_reg.amb_res[15:8], s_reg.amb_res[7:0]};
         OFS_FLAGS: rd_word = {24'h00_0000, s_reg.flags};
         OFS_ID: rd_word = {16'h0000, DEVICE_ID};
         default: rd_err = 1'b1;
      endcase
   end

   // =====================================================================
   // decode and derived terms
   always_comb begin
      // access completes only on the edge that sees our pready high
      apb_done = PSEL & PENABLE & s_reg.pready;
      apb_wr = apb_done & PWRITE;
      apb_rd = apb_done & ~PWRITE;
      lclk_rise = s_reg.lclk_s[1] & ~s_reg.lclk_s[2];
      prox_raw = s_reg.pdata_s[1];
      // saturate instead of wrapping on large cancel values
      prox_val = (prox_raw > s_reg.cancel) ? prox_raw - s_reg.cancel : 16'h0000;
      amb_tick = s_reg.amb_conf[AMB_ON_BIT] && (s_reg.amb_timer == 32'h0000_0000);
      amb_need = 4'h1 << s_reg.amb_conf[AMB_PERS_LSB +: 2];
      amb_inc = (s_reg.amb_cnt == 4'h8) ? 4'h8 : s_reg.amb_cnt + 4'h1;
      amb_out = (s_reg.adata_s[1] > s_reg.amb_high) ||
                (s_reg.adata_s[1] < s_reg.amb_low);
      // method 1 uses the low limit for away, method 0 just the high limit
      if (s_reg.near) begin
         prox_out = s_reg.prox_conf[PROX_METHOD_BIT] ? (prox_val < s_reg.prox_low)
                                                     : (prox_val <= s_reg.prox_high);
      end else begin
         prox_out = prox_val > s_reg.prox_high;
      end
      prox_inc = (s_reg.prox_cnt == 3'd4) ? 3'd4 : s_reg.prox_cnt + 3'd1;
      emit_idx = (s_reg.prox_conf[PROX_EMIT_LSB +: 2] == 2'd3) ? 2'd0
                                                               : s_reg.prox_conf[PROX_EMIT_LSB +: 2];
      // forced mode waits for a trigger, otherwise measure back to back
      start_ok = s_reg.prox_conf[PROX_ON_BIT] &&
                 (!s_reg.prox_conf[PROX_FORCED_BIT] || s_reg.prox_conf[PROX_TRIG_BIT]);
      irq_on = |s_reg.prox_conf[PROX_IRQ_SEL_LSB +: 2];
      irq_mask = 8'h00;
      irq_mask[FLG_GESTURE] = irq_on;
      irq_mask[FLG_PROTECT] = irq_on;
      irq_mask[FLG_AMB_LOW] = s_reg.amb_conf[AMB_IRQ_EN_BIT];
      irq_mask[FLG_AMB_HIGH] = s_reg.amb_conf[AMB_IRQ_EN_BIT];
      irq_mask[FLG_NEAR] = s_reg.prox_conf[PROX_IRQ_SEL_LSB];
      irq_mask[FLG_FAR] = s_reg.prox_conf[PROX_IRQ_SEL_LSB + 1];
   end

   // =====================================================================
   // next state
   always_comb begin
      s_next = s_reg;
      fset = 8'h00;

      // synchronisers, first stage read only by the second
      s_next.lclk_s = {s_reg.lclk_s[1:0], LINK_CLK};
      s_next.pvalid_s = {s_reg.pvalid_s[0], PRX_VALID};
      s_next.pdata_s = {s_reg.pdata_s[0], PRX_DATA};
      s_next.adata_s = {s_reg.adata_s[0], AMB_DATA};
      s_next.prot_s = {s_reg.prot_s[1:0], PROTECT_IN};
      if (s_reg.prot_s[1] && !s_reg.prot_s[2]) begin
         fset[FLG_PROTECT] = 1'b1;
      end

      // apb: one wait state, pready and prdata from flops
      s_next.pready = PSEL & PENABLE & ~s_reg.pready;
      s_next.pslverr = PSEL & PENABLE & ~s_reg.pready & rd_err;
      s_next.prdata = (PSEL & PENABLE & ~s_reg.pready & ~PWRITE & ~rd_err) ? rd_word
                                                                            : 32'h0000_0000;

      // ambient integration timer and persistence
      if (!s_reg.amb_conf[AMB_ON_BIT]) begin
         s_next.amb_timer = amb_period(s_reg.amb_conf[AMB_IT_LSB +: 3]);
         s_next.amb_cnt = 4'h0;
      end else if (amb_tick) begin
         s_next.amb_timer = amb_period(s_reg.amb_conf[AMB_IT_LSB +: 3]) - 32'h0000_0001;
         s_next.amb_res = s_reg.adata_s[1];
         if (amb_out) begin
            s_next.amb_cnt = amb_inc;
            // stays asserted every period while the run lasts
            if (amb_inc >= amb_need) begin
               fset[FLG_AMB_HIGH] = s_reg.adata_s[1] > s_reg.amb_high;
               fset[FLG_AMB_LOW] = s_reg.adata_s[1] < s_reg.amb_low;
            end
         end else begin
            s_next.amb_cnt = 4'h0;
         end
      end else begin
         s_next.amb_timer = s_reg.amb_timer - 32'h0000_0001;
      end

      // proximity measurement sequencer
      unique case (s_reg.pstate)
         PAE_P_IDLE: begin
            if (start_ok) begin
               s_next.prox_conf[PROX_TRIG_BIT] = 1'b0;
               s_next.gesture_run = s_reg.prox_conf[PROX_GESTURE_BIT] &&
                                    s_reg.prox_conf[PROX_FORCED_BIT];
               s_next.emitter = s_next.gesture_run ? 2'd0 : emit_idx;
               s_next.emit_sel = 3'b001 << s_next.emitter;
               s_next.prox_req = 1'b1;
               s_next.pstate = PAE_P_WAIT;
            end
         end
         PAE_P_WAIT: begin
            if (lclk_rise && s_reg.pvalid_s[1]) begin
               s_next.prox_res[s_reg.emitter] = prox_val;
               if (s_reg.gesture_run) begin
                  if (s_reg.emitter == 2'd2) begin
                     fset[FLG_GESTURE] = 1'b1;
                     s_next.gesture_run = 1'b0;
                     s_next.prox_req = 1'b0;
                     s_next.emit_sel = 3'b000;
                     s_next.pstate = PAE_P_IDLE;
                  end else begin
                     // next emitter in turn, request stays up
                     s_next.emitter = s_reg.emitter + 2'd1;
                     s_next.emit_sel = {s_reg.emit_sel[1:0], 1'b0};
                  end
               end else begin
                  s_next.prox_req = 1'b0;
                  s_next.emit_sel = 3'b000;
                  s_next.pstate = PAE_P_IDLE;
                  if (prox_out) begin
                     s_next.prox_cnt = prox_inc;
                     if (prox_inc > s_reg.prox_conf[PROX_PERS_LSB +: 2]) begin
                        s_next.near = ~s_reg.near;
                        s_next.prox_cnt = 3'd0;
                        fset[FLG_NEAR] = ~s_reg.near;
                        fset[FLG_FAR] = s_reg.near;
                     end
                  end else begin
                     s_next.prox_cnt = 3'd0;
                  end
               end
            end
         end
      endcase
      if (!s_reg.prox_conf[PROX_ON_BIT]) begin
         s_next.near = 1'b0;
         s_next.prox_cnt = 3'd0;
      end

      // register writes, applied after hardware updates
      if (apb_wr) begin
         unique case (PADDR)
            OFS_AMB_CONF: s_next.amb_conf = PWDATA[7:0];
            OFS_PROX_CONF: begin
               s_next.prox_conf = PWDATA[11:0];
               // the or sees only the new write data, so a zero write drops a trigger still pending
               s_next.prox_conf[PROX_TRIG_BIT] = PWDATA[PROX_TRIG_BIT] |
                                                 s_next.prox_conf[PROX_TRIG_BIT];
            end
            OFS_AMB_HIGH: s_next.amb_high = PWDATA[15:0];
            OFS_AMB_LOW: s_next.amb_low = PWDATA[15:0];
            OFS_PROX_HIGH: s_next.prox_high = PWDATA[15:0];
            OFS_PROX_LOW: s_next.prox_low = PWDATA[15:0];
            OFS_CANCEL: s_next.cancel = PWDATA[15:0];
            default: begin
            end
         endcase
      end

      // flags: read clears, a set in the same cycle wins
      if (apb_rd && (PADDR == OFS_FLAGS)) begin
         s_next.flags = fset;
      end else begin
         s_next.flags = s_reg.flags | fset;
      end

      // open-drain pin, drives low while asserted
      s_next.pin_o = 1'b0;
      if (s_reg.prox_conf[PROX_PIN_SEL_BIT]) begin
         s_next.pin_oe_n = ~s_next.near;
      end else begin
         s_next.pin_oe_n = ~|(s_next.flags & irq_mask);
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         s_reg <= '0;
         s_reg.amb_conf <= RST_AMB_CONF;
         s_reg.prox_conf <= RST_PROX_CONF;
         s_reg.amb_high <= RST_HIGH_LIMIT;
         s_reg.amb_low <= RST_LOW_LIMIT;
         s_reg.prox_high <= RST_HIGH_LIMIT;
         s_reg.prox_low <= RST_LOW_LIMIT;
         s_reg.pstate <= PAE_P_IDLE;
         s_reg.pin_oe_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA = s_reg.prdata;
   assign PREADY = s_reg.pready;
   assign PSLVERR = s_reg.pslverr;
   assign PRX_REQ = s_reg.prox_req;
   assign EMIT_SEL = s_reg.emit_sel;
   assign IRQ_PIN_O = s_reg.pin_o;
   assign IRQ_PIN_OE_N = s_reg.pin_oe_n;

endmodule

// file: test/pae_frontend.sv
// behavioural analog front end answering each measurement request
// assumes the block holds prx_req and a one-hot emit_sel until the answer
`timescale 1ns/1ps
module pae_frontend (
   input wire logic prx_req,
   input wire logic [2:0] emit_sel,
   input wire logic [15:0] raw0,
   input wire logic [15:0] raw1,
   input wire logic [15:0] raw2,
   output logic link_clk,
   output logic prx_valid,
   output logic [15:0] prx_data
);
   // ==========
   // link clock runs only within a measurement
   initial begin
      link_clk = 1'b0;
      prx_valid = 1'b0;
      prx_data = 16'h0;
      forever begin
         wait (prx_req === 1'b1);
         #7;
         prx_data = emit_sel[2] ? raw2 : (emit_sel[1] ? raw1 : raw0);
         prx_valid = 1'b1;
         #25 link_clk = 1'b1;
         #32 link_clk = 1'b0;
         // stale data inverted so a late capture shows
         prx_valid = 1'b0;
         prx_data = ~prx_data;
         #32;
      end
   end
endmodule

// file: test/pae_top_asserts.sv
// concurrent checks on the ports of the proximity / ambient event block
// assumes pae_pkg is compiled first; bound to every pae_top at the foot
`timescale 1ns/1ps
module pae_top_asserts
   import pae_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic LINK_CLK,
   input wire logic PRX_VALID,
   input wire logic [15:0] PRX_DATA,
   input wire logic [15:0] AMB_DATA,
   input wire logic PROTECT_IN,
   input wire logic PRX_REQ,
   input wire logic [2:0] EMIT_SEL,
   input wire logic IRQ_PIN_O,
   input wire logic IRQ_PIN_OE_N
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic done;
   logic rd_done;
   logic trig_wr;
   assign done = PSEL && PENABLE && PREADY;
   assign rd_done = done && !PWRITE;
   assign trig_wr = done && PWRITE && PADDR == OFS_PROX_CONF && PWDATA[PROX_ON_BIT]
      && PWDATA[PROX_FORCED_BIT] && PWDATA[PROX_TRIG_BIT];
   // ==========
   // register bus
   sequence acc_start;
      PSEL && PENABLE && !$past(PENABLE);
   endsequence
   ready_wait_a: assert property (acc_start |-> !PREADY ##1 PREADY)
      else $error("ready not in second access cycle");
   ready_once_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error response malformed");
   rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   id_read_a: assert property (rd_done && PADDR == OFS_ID |-> PRDATA == {16'h0, DEVICE_ID})
      else $error("identity read wrong");
   flag_layout_a: assert property (rd_done && PADDR == OFS_FLAGS |-> PRDATA[31:8] == 24'h0
      && PRDATA[3:2] == 2'b00)
      else $error("flag byte has bits outside its fields");
   // ==========
   // pin and measurement link
   pin_drain_a: assert property (IRQ_PIN_O == 1'b0)
      else $error("pin data not low");
   emit_onehot_a: assert property (PRX_REQ |-> $onehot(EMIT_SEL))
      else $error("emitter select not one-hot");
   trig_req_a: assert property (trig_wr |-> ##[1:4] PRX_REQ)
      else $error("trigger write started no measurement");
   sequence link_take;
      PRX_REQ && PRX_VALID && $rose(LINK_CLK);
   endsequence
   sequence req_moves;
      ##[2:7] (!PRX_REQ || $changed(EMIT_SEL));
   endsequence
   link_capture_a: assert property (link_take |-> req_moves)
      else $error("result not taken after link edge");
endmodule
bind pae_top pae_top_asserts chk_i (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .LINK_CLK(LINK_CLK), .PRX_VALID(PRX_VALID), .PRX_DATA(PRX_DATA),
   .AMB_DATA(AMB_DATA), .PROTECT_IN(PROTECT_IN), .PRX_REQ(PRX_REQ), .EMIT_SEL(EMIT_SEL),
   .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE_N(IRQ_PIN_OE_N));

// file: test/tb.sv
// self-checking bench of the proximity / ambient event block
// assumes pae_pkg, pae_top, pae_frontend and the checker compiled before it
`timescale 1ns/1ps
module tb
   import pae_pkg::*;
;
   localparam logic [31:0] P_ON = 32'h1 << PROX_ON_BIT;
   localparam logic [31:0] P_FRC = 32'h1 << PROX_FORCED_BIT;
   localparam logic [31:0] P_TRG = 32'h1 << PROX_TRIG_BIT;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, link_clk, prx_valid;
   logic protect_in, prx_req, pin_o, pin_oe_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] prx_data, amb_data, raw0, raw1, raw2;
   logic [2:0] emit_sel;
   int error_cnt = 0;
   int n_compared = 0;
   pae_top #(.AMB_BASE(20)) dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LINK_CLK(link_clk), .PRX_VALID(prx_valid), .PRX_DATA(prx_data),
      .AMB_DATA(amb_data), .PROTECT_IN(protect_in), .PRX_REQ(prx_req), .EMIT_SEL(emit_sel),
      .IRQ_PIN_O(pin_o), .IRQ_PIN_OE_N(pin_oe_n));
   pae_frontend fe (.prx_req(prx_req), .emit_sel(emit_sel), .raw0(raw0), .raw1(raw1),
      .raw2(raw2), .link_clk(link_clk), .prx_valid(prx_valid), .prx_data(prx_data));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // ==========
   // shared tasks
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk({31'h0, pready}, 32'h1, "pready timeout");
         finish_test();
      end
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string s);
      logic [31:0] q;
      rd(a, q);
      chk(q, x, s);
   endtask
   // one measurement round trip; bounded so a dead link ends the run
   task automatic trig(input logic [31:0] c);
      int n;
      logic seen;
      wr(OFS_PROX_CONF, c | P_TRG);
      n = 0;
      while (prx_req !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      seen = (prx_req === 1'b1);
      while (prx_req !== 1'b0 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      if (!seen || n >= 400) begin
         chk({31'h0, seen}, 32'h1, "measurement timeout");
         finish_test();
      end
      wt(4);
   endtask
   // ==========
   // scenarios
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rdc(OFS_AMB_HIGH, 32'hffff, "amb high reset");
      rdc(OFS_PROX_LOW, 32'h0, "prox low reset");
      rdc(OFS_ID, {16'h0, DEVICE_ID}, "id");
      apb(1'b0, 8'h34, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      wr(OFS_CANCEL, 32'h1234);
      rdc(OFS_CANCEL, 32'h1234, "cancel");
      protect_in <= 1'b1;
      wt(8);
      rdc(OFS_FLAGS, 32'h40, "protect flag");
   endtask
   task automatic t_forced();
      wr(OFS_CANCEL, 32'h10);
      raw0 <= 16'h100;
      trig(P_ON | P_FRC);
      rdc(OFS_PROX_RES0, 32'hf0, "res0");
      raw0 <= 16'h300;
      wt(200);
      rdc(OFS_PROX_RES0, 32'hf0, "res0 standby");
      wr(OFS_CANCEL, 32'h400);
      trig(P_ON | P_FRC);
      rdc(OFS_PROX_RES0, 32'h0, "res0 floor");
      wr(OFS_CANCEL, 32'h0);
      raw1 <= 16'h44;
      trig(P_ON | P_FRC | (32'h1 << PROX_EMIT_LSB));
      rdc(OFS_PROX_RES1, 32'h44, "res1");
   endtask
   task automatic t_prox();
      logic [31:0] c;
      // both events, method 1, two periods
      c = P_ON | P_FRC | 32'h1e;
      wr(OFS_PROX_HIGH, 32'h200);
      wr(OFS_PROX_LOW, 32'h80);
      raw0 <= 16'h300;
      trig(c);
      raw0 <= 16'h100;
      trig(c);
      raw0 <= 16'h300;
      trig(c);
      chk({31'h0, pin_oe_n}, 32'h1, "pin broken run");
      trig(c);
      chk({31'h0, pin_oe_n}, 32'h0, "pin near");
      rdc(OFS_PROX_HIGH, 32'h200, "limit under irq");
      rdc(OFS_FLAGS, 32'h2, "near flag");
      wt(3);
      chk({31'h0, pin_oe_n}, 32'h1, "pin released");
      raw0 <= 16'h100;
      trig(c);
      trig(c);
      chk({31'h0, pin_oe_n}, 32'h1, "pin between");
      raw0 <= 16'h40;
      trig(c);
      trig(c);
      rdc(OFS_FLAGS, 32'h1, "far flag");
   endtask
   task automatic t_logic();
      logic [31:0] q;
      raw0 <= 16'h300;
      trig(P_ON | P_FRC | 32'h5e);
      trig(P_ON | P_FRC | 32'h5e);
      chk({31'h0, pin_oe_n}, 32'h0, "logic near");
      rd(OFS_FLAGS, q);
      wt(3);
      chk({31'h0, pin_oe_n}, 32'h0, "logic after read");
      raw0 <= 16'h40;
      trig(P_ON | P_FRC | 32'h5e);
      trig(P_ON | P_FRC | 32'h5e);
      chk({31'h0, pin_oe_n}, 32'h1, "logic far");
      rd(OFS_FLAGS, q);
   endtask
   task automatic t_gesture();
      logic [31:0] q;
      raw0 <= 16'h11;
      raw1 <= 16'h22;
      raw2 <= 16'h33;
      trig(P_ON | P_FRC | 32'h6 | (32'h1 << PROX_GESTURE_BIT));
      chk({31'h0, pin_oe_n}, 32'h0, "gesture pin");
      rd(OFS_FLAGS, q);
      chk(q & 32'h80, 32'h80, "gesture flag");
      rdc(OFS_PROX_RES0, 32'h11, "gesture res0");
      rdc(OFS_PROX_RES1, 32'h22, "gesture res1");
      rdc(OFS_PROX_RES2, 32'h33, "gesture res2");
   endtask
   task automatic t_amb();
      logic [31:0] q;
      wr(OFS_PROX_CONF, 32'h0);
      rd(OFS_FLAGS, q);
      wr(OFS_AMB_HIGH, 32'h1000);
      amb_data <= 16'h2345;
      // on, irq enabled, four periods of 20 cycles
      wr(OFS_AMB_CONF, 32'h0b);
      wt(50);
      chk({31'h0, pin_oe_n}, 32'h1, "amb early");
      wt(60);
      chk({31'h0, pin_oe_n}, 32'h0, "amb late");
      rdc(OFS_AMB_RES, 32'h2345, "amb result");
      // read before the data moves, so only the high crossing can be set
      rd(OFS_FLAGS, q);
      chk(q & 32'h30, 32'h10, "amb high flag");
      amb_data <= 16'h0010;
      wr(OFS_AMB_LOW, 32'h100);
      wr(OFS_AMB_CONF, 32'h03);
      // one period may still carry the old data; clear what it set
      wt(25);
      rd(OFS_FLAGS, q);
      wt(50);
      rd(OFS_FLAGS, q);
      chk(q & 32'h30, 32'h20, "amb low flag");
   endtask
   // ==========
   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      amb_data = 16'h0;
      protect_in = 1'b0;
      raw0 = 16'h0;
      raw1 = 16'h0;
      raw2 = 16'h0;
      wt(10);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_regs();
      t_forced();
      t_prox();
      t_logic();
      t_gesture();
      t_amb();
      finish_test();
   end
endmodule
